// >>> core/ppu_pkg.sv
/*
 * shared constants, field positions and carrier types of the parallel port unit
 * assumes an apb master with 32-bit data and a single 50 mhz clock
 */
// Summary of operation
// - eleven byte registers in a sixteen-location window
// - line data write drives the port lines
// - line data read returns the live lines
// - status bits 0-4 show the port inputs
// - status bits 5-7: empty, full, command pending
// - control bit 2 selects data bus direction
// - ack rising edge raises interrupt when enabled
// - control bits 4-7 drive the four outputs
// - control register reads zero after reset
// - forward count shows bytes not yet sent
// - reverse count shows bytes not yet read
// - fifo status bit 5: one word present
// - fifo status bit 6: room for a word
// - dma enable rising edge raises dma request
// - dma grant drops the dma request
// - dma enable clears on count done or write
// - flush bit pulses queue flush one cycle
// - reset bit pulses unit reset one cycle
// - sixteen-byte queue accessed in access words
// - command pending clears on reset, read, sent
package ppu_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_QUEUE    = 10'h370;
	localparam logic [9:0] IDX_CMD      = 10'h374;
	localparam logic [9:0] IDX_TIMEOUT  = 10'h375;
	localparam logic [9:0] IDX_LINE     = 10'h378;
	localparam logic [9:0] IDX_STATUS   = 10'h379;
	localparam logic [9:0] IDX_CONTROL  = 10'h37a;
	localparam logic [9:0] IDX_FSTATUS  = 10'h37b;
	localparam logic [9:0] IDX_FCONTROL = 10'h37c;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h37d;
	localparam logic [9:0] IDX_IRQ_CAUS = 10'h37e;
	localparam logic [9:0] IDX_SNAPSHOT = 10'h37f;
	localparam logic [9:0] IDX_RSVD_LO  = 10'h376;
	localparam logic [9:0] IDX_RSVD_HI  = 10'h377;

	// port control fields
	localparam int CTL_DIR    = 2;
	localparam int CTL_ACK_IE = 3;
	localparam int CTL_SELIN  = 4;
	localparam int CTL_INIT   = 5;
	localparam int CTL_AUTOFD = 6;
	localparam int CTL_STROBE = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// fifo control fields
	localparam int QCTL_DMA   = 0;
	localparam int QCTL_FLUSH = 1;
	localparam int QCTL_URST  = 2;
	localparam int QCTL_WIDE  = 3;
	localparam logic [7:0] QCTL_RESET = 8'h00;

	// irq cause bit set by an ack rising edge
	localparam int CAUSE_ACK = 7;

	// queue geometry and access word sizes
	localparam logic [4:0] QDEPTH      = 5'h10;
	localparam logic [2:0] WORD_NARROW = 3'h1;
	localparam logic [2:0] WORD_WIDE   = 3'h4;

	// port inputs as seen on the pins
	typedef struct packed {
		logic busy;
		logic ack_n;
		logic perror;
		logic select;
		logic fault_n;
	} port_in_s;

	// port control outputs, all pin levels
	typedef struct packed {
		logic select_in_n;
		logic init_n;
		logic auto_feed_n;
		logic strobe_n;
	} port_out_s;

endpackage : ppu_pkg

// >>> core/parallel_port_unit.sv
/*
 * register and queue logic of the parallel port unit behind an apb slave
 * assumes port inputs synchronous to clk_i and a port engine that takes
 * forward bytes and hands in reverse bytes one per handshake
 */
// The APB slave port was decided locally.
module parallel_port_unit
	import ppu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// parallel port pins
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_o,
	input  wire port_in_s    port_in_i,
	output port_out_s        port_out_o,
	output logic             ack_irq_o,
	// port engine side of the queue and command byte
	output logic      [7:0]  fwd_byte_o,
	output logic             fwd_valid_o,
	input  wire logic        fwd_take_i,
	input  wire logic [7:0]  rev_byte_i,
	input  wire logic        rev_valid_i,
	output logic      [7:0]  cmd_byte_o,
	output logic             cmd_pending_o,
	input  wire logic        cmd_sent_i,
	// dma handshake
	output logic             dma_request_line_o,
	input  wire logic        dma_grant_line_i,
	input  wire logic        dma_count_done_i
);

	logic [7:0]  queue_mem [16];
	logic [3:0]  wr_ptr_ff;
	logic [3:0]  rd_ptr_ff;
	logic [4:0]  count_ff;
	logic [4:0]  nxt_count;
	logic [7:0]  line_data_ff;
	logic [7:0]  ctl_ff;
	logic [7:0]  qctl_ff;
	logic [7:0]  timeout_ff;
	logic [7:0]  irq_mask_ff;
	logic [7:0]  cause_ff;
	logic [7:0]  snapshot_ff;
	logic        xrun_ff;
	logic        flush_ff;
	logic        unit_rst_ff;
	logic        ack_prev_ff;
	logic        dma_en_ff;
	logic [31:0] nxt_rdata;
	logic        nxt_err;
	logic [9:0]  idx;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic        fwd;
	logic [2:0]  step;
	logic [4:0]  room;
	logic        room_ok;
	logic        data_ok;
	logic        cpu_push;
	logic        cpu_pop;
	logic        port_push;
	logic        port_pop;
	logic        xrun_evt;
	logic [4:0]  push_n;
	logic [4:0]  pop_n;
	logic        wr_ctl;
	logic        wr_qctl;
	logic        wr_cmd;
	logic        clr_all;

	// bus decode; the access edge is the one where pready is high
	assign idx    = paddr_i[11:2];
	assign acc    = psel_i && penable_i && pready_o;
	assign wr_acc = acc && pwrite_i;
	assign rd_acc = acc && !pwrite_i;
	assign wr_ctl = wr_acc && (idx == IDX_CONTROL);
	assign wr_qctl = wr_acc && (idx == IDX_FCONTROL);
	assign wr_cmd = wr_acc && (idx == IDX_CMD);
	assign clr_all = unit_rst_ff;

	// queue accounting; direction decides who fills and who drains
	assign fwd      = !ctl_ff[CTL_DIR];
	assign step     = qctl_ff[QCTL_WIDE] ? WORD_WIDE : WORD_NARROW;
	assign room     = QDEPTH - count_ff;
	assign room_ok  = room >= {2'b00, step};
	assign data_ok  = count_ff >= {2'b00, step};
	assign cpu_push = wr_acc && (idx == IDX_QUEUE) && fwd && room_ok;
	assign cpu_pop  = rd_acc && (idx == IDX_QUEUE) && !fwd && data_ok;
	assign port_push = rev_valid_i && !fwd && (count_ff != QDEPTH);
	assign port_pop  = fwd_take_i && fwd_valid_o;
	// a word that does not fit, or is not there, is dropped and flagged
	assign xrun_evt = (wr_acc && (idx == IDX_QUEUE) && fwd && !room_ok)
		|| (rd_acc && (idx == IDX_QUEUE) && !fwd && !data_ok)
		|| (rev_valid_i && !fwd && (count_ff == QDEPTH));
	assign push_n = cpu_push ? {2'b00, step} : (port_push ? 5'h01 : 5'h00);
	assign pop_n  = cpu_pop ? {2'b00, step} : (port_pop ? 5'h01 : 5'h00);
	assign nxt_count = count_ff + push_n - pop_n;

	// read mux is evaluated in the setup cycle so prdata can come from a flop
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_err   = 1'b0;
		case (idx)
			IDX_QUEUE:
			begin
				for (int k = 0; k < 4; k++)
				begin
					if (3'(k) < step)
						nxt_rdata[8*k +: 8] = queue_mem[rd_ptr_ff + 4'(k)];
				end
			end
			IDX_CMD:      nxt_rdata[7:0] = cmd_byte_o;
			IDX_TIMEOUT:  nxt_rdata[7:0] = timeout_ff;
			IDX_LINE:     nxt_rdata[7:0] = data_i;
			IDX_STATUS:   nxt_rdata[7:0] = {cmd_pending_o, count_ff == QDEPTH,
				count_ff == 5'h00, port_in_i.fault_n, port_in_i.select,
				port_in_i.perror, port_in_i.ack_n, !port_in_i.busy};
			IDX_CONTROL:  nxt_rdata[7:0] = ctl_ff;
			IDX_FSTATUS:  nxt_rdata[7:0] = {xrun_ff, room_ok, data_ok, count_ff};
			IDX_FCONTROL: nxt_rdata[7:0] = qctl_ff;
			IDX_IRQ_MASK: nxt_rdata[7:0] = irq_mask_ff;
			IDX_IRQ_CAUS: nxt_rdata[7:0] = cause_ff;
			IDX_SNAPSHOT: nxt_rdata[7:0] = snapshot_ff;
			// reserved slots 0x376/0x377 read zero without error
			IDX_RSVD_LO, IDX_RSVD_HI: nxt_rdata = 32'h0000_0000;
			default:      nxt_err = 1'b1;
		endcase
	end

	// apb answer: one wait-free access cycle after every setup cycle
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else
		begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && nxt_err;
			prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? nxt_rdata : 32'h0000_0000;
		end
	end

	// one-cycle pulses from the fifo control register
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			flush_ff    <= 1'b0;
			unit_rst_ff <= 1'b0;
		end
		else
		begin
			flush_ff    <= wr_qctl && pwdata_i[QCTL_FLUSH];
			unit_rst_ff <= wr_qctl && pwdata_i[QCTL_URST];
		end
	end

	// plain software registers, all cleared by the unit reset pulse
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			line_data_ff <= 8'h00;
			ctl_ff       <= CTL_RESET;
			timeout_ff   <= 8'h00;
			irq_mask_ff  <= 8'h00;
			qctl_ff      <= QCTL_RESET;
		end
		else if (clr_all)
		begin
			line_data_ff <= 8'h00;
			ctl_ff       <= CTL_RESET;
			timeout_ff   <= 8'h00;
			irq_mask_ff  <= 8'h00;
			qctl_ff      <= QCTL_RESET;
		end
		else if (wr_acc)
		begin
			if (idx == IDX_LINE)
				line_data_ff <= pwdata_i[7:0];
			if (idx == IDX_CONTROL)
				ctl_ff <= {pwdata_i[7:2], 2'b00};
			if (idx == IDX_TIMEOUT)
				timeout_ff <= pwdata_i[7:0];
			if (idx == IDX_IRQ_MASK)
				irq_mask_ff <= pwdata_i[7:0];
			// pulse bits never stick; dma enable lives in its own flop
			if (idx == IDX_FCONTROL)
				qctl_ff <= {pwdata_i[7:3], 3'b000};
		end
	end

	// pin drivers lag the register by one cycle so every pin is a flop
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			data_o     <= 8'h00;
			data_oe_o  <= 1'b1;
			port_out_o <= '{select_in_n: 1'b1, init_n: 1'b0, auto_feed_n: 1'b1,
				strobe_n: 1'b1};
		end
		else
		begin
			data_o                 <= line_data_ff;
			data_oe_o              <= !ctl_ff[CTL_DIR];
			port_out_o.select_in_n <= !ctl_ff[CTL_SELIN];
			port_out_o.init_n      <= ctl_ff[CTL_INIT];
			port_out_o.auto_feed_n <= !ctl_ff[CTL_AUTOFD];
			port_out_o.strobe_n    <= !ctl_ff[CTL_STROBE];
		end
	end

	// ack edges: rise interrupts, fall latches the data lines
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ack_prev_ff <= 1'b1;
			ack_irq_o   <= 1'b0;
			snapshot_ff <= 8'h00;
			cause_ff    <= 8'h00;
		end
		else
		begin
			ack_prev_ff <= port_in_i.ack_n;
			ack_irq_o   <= port_in_i.ack_n && !ack_prev_ff && ctl_ff[CTL_ACK_IE];
			if (!port_in_i.ack_n && ack_prev_ff)
				snapshot_ff <= data_i;
			// set wins over the clear by a status read
			if (port_in_i.ack_n && !ack_prev_ff && ctl_ff[CTL_ACK_IE])
				cause_ff[CAUSE_ACK] <= 1'b1;
			else if (clr_all || (rd_acc && idx == IDX_STATUS))
				cause_ff[CAUSE_ACK] <= 1'b0;
		end
	end

	// command byte; a new write outranks a same-cycle clear
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cmd_byte_o    <= 8'h00;
			cmd_pending_o <= 1'b0;
		end
		else if (wr_cmd)
		begin
			cmd_byte_o    <= pwdata_i[7:0];
			cmd_pending_o <= 1'b1;
		end
		else if (clr_all || (rd_acc && idx == IDX_CMD) || cmd_sent_i)
			cmd_pending_o <= 1'b0;
	end

	// dma enable and request
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dma_en_ff          <= 1'b0;
			dma_request_line_o <= 1'b0;
		end
		else if (clr_all)
		begin
			dma_en_ff          <= 1'b0;
			dma_request_line_o <= 1'b0;
		end
		else
		begin
			if (wr_qctl)
				dma_en_ff <= pwdata_i[QCTL_DMA];
			else if (dma_count_done_i)
				dma_en_ff <= 1'b0;
			// only the rising edge of enable raises the request
			if (wr_qctl && pwdata_i[QCTL_DMA] && !dma_en_ff)
				dma_request_line_o <= 1'b1;
			else if (dma_grant_line_i)
				dma_request_line_o <= 1'b0;
		end
	end

	// queue storage; lanes fill lowest byte first
	always_ff @(posedge clk_i)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (cpu_push && (3'(k) < step))
				queue_mem[wr_ptr_ff + 4'(k)] <= pwdata_i[8*k +: 8];
		end
		if (port_push)
			queue_mem[wr_ptr_ff] <= rev_byte_i;
	end

	// queue pointers and count
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_ptr_ff <= 4'h0;
			rd_ptr_ff <= 4'h0;
			count_ff  <= 5'h00;
		end
		else if (clr_all || flush_ff)
		begin
			wr_ptr_ff <= 4'h0;
			rd_ptr_ff <= 4'h0;
			count_ff  <= 5'h00;
		end
		else
		begin
			wr_ptr_ff <= wr_ptr_ff + push_n[3:0];
			rd_ptr_ff <= rd_ptr_ff + pop_n[3:0];
			count_ff  <= nxt_count;
		end
	end

	// sticky overrun/underrun flag
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			xrun_ff <= 1'b0;
		else if (xrun_evt)
			xrun_ff <= 1'b1;
		else if (clr_all || flush_ff)
			xrun_ff <= 1'b0;
	end

	// forward head byte; valid drops for one cycle after each take
	// so the head is always refetched from the moved read pointer
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fwd_byte_o  <= 8'h00;
			fwd_valid_o <= 1'b0;
		end
		else
		begin
			fwd_byte_o  <= queue_mem[rd_ptr_ff];
			fwd_valid_o <= fwd && !port_pop && !flush_ff && !clr_all && (count_ff != 5'h00);
		end
	end

	a_ack_irq_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
		($rose(port_in_i.ack_n) && ctl_ff[CTL_ACK_IE]) |=> ack_irq_o)
		else $error("ack rise did not raise interrupt");

	a_dir_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
		wr_ctl |=> ##1 (data_oe_o == !$past(pwdata_i[CTL_DIR], 2)))
		else $error("data direction does not follow control bit");

	a_ctl_pins: assert property (@(posedge clk_i) disable iff (!resetn_i)
		wr_ctl |=> ##1 (port_out_o.strobe_n == !$past(pwdata_i[CTL_STROBE], 2))
			&& (port_out_o.init_n == $past(pwdata_i[CTL_INIT], 2)))
		else $error("control pins wrong after write");

	a_unit_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
		unit_rst_ff |=> (ctl_ff == CTL_RESET) && (count_ff == 5'h00) && !cmd_pending_o)
		else $error("unit reset left state behind");

	a_dma_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_qctl && pwdata_i[QCTL_DMA] && !dma_en_ff) |=> dma_request_line_o)
		else $error("dma enable rise gave no request");

	a_dma_grant: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(dma_request_line_o && dma_grant_line_i && !wr_qctl && !clr_all) |=> !dma_request_line_o)
		else $error("request held after grant");

	a_dma_done: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(dma_count_done_i && !wr_qctl) |=> !dma_en_ff)
		else $error("dma enable survived count done");

	a_flush_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_qctl && pwdata_i[QCTL_FLUSH]) |=> flush_ff ##1 (!flush_ff && count_ff == 5'h00))
		else $error("flush pulse wrong");

	a_urst_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_qctl && pwdata_i[QCTL_URST]) |=> unit_rst_ff ##1 !unit_rst_ff)
		else $error("unit reset pulse wrong");

	a_count_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(count_ff <= QDEPTH) && ((count_ff == QDEPTH) -> !room_ok))
		else $error("queue count out of range");

	a_xrun_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(xrun_evt || (xrun_ff && !flush_ff && !clr_all)) |=> xrun_ff)
		else $error("xrun flag lost");

	a_cmd_pending: assert property (@(posedge clk_i) disable iff (!resetn_i)
		wr_cmd |=> cmd_pending_o)
		else $error("command write did not set pending");

endmodule : parallel_port_unit

// >>> tb/printer_model.sv
/*
 * peripheral model on the far side of the parallel port unit
 * assumes the bench sets pin levels, stall and the byte it drives in reverse
 */
module printer_model
	import ppu_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       stall_i,
	input  wire port_in_s   pins_i,
	input  wire logic [7:0] drive_i,
	input  wire logic [7:0] unit_data_i,
	input  wire logic       unit_oe_i,
	input  wire logic [7:0] fwd_byte_i,
	input  wire logic       fwd_valid_i,
	input  wire logic       cmd_pending_i,
	output logic      [7:0] line_o,
	output port_in_s        port_in_o,
	output logic            fwd_take_o,
	output logic            cmd_sent_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [$];

	// one owner at a time: the unit in forward, this side in reverse
	assign line_o    = unit_oe_i ? unit_data_i : drive_i;
	assign port_in_o = pins_i;

	// one byte per take, with a gap after each; stall models a slow printer
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fwd_take_o <= 1'b0;
			cmd_sent_o <= 1'b0;
		end
		else
		begin
			fwd_take_o <= fwd_valid_i && !fwd_take_o && !stall_i;
			cmd_sent_o <= cmd_pending_i && !cmd_sent_o && !stall_i;
			if (fwd_take_o && fwd_valid_i)
				got.push_back(fwd_byte_i);
		end
	end
endmodule : printer_model

// >>> tb/tb_top.sv
/*
 * self-checking bench of the parallel port unit, one task per scenario
 * assumes ppu_pkg, the unit and the peripheral model are compiled first
 */
module tb_top
	import ppu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  data_o, line, drive, fwd_byte, cmd_byte;
	logic        data_oe, ack_irq, fwd_valid, fwd_take, rev_valid, hit;
	logic        cmd_pending, cmd_sent, stall, dma_req, dma_grant, dma_done;
	port_in_s    pins, port_in;
	port_out_s   port_out;
	int          fails, n_compared;

	parallel_port_unit u_parallel_port_unit (
		.clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .data_i(line), .data_o(data_o),
		.data_oe_o(data_oe), .port_in_i(port_in), .port_out_o(port_out),
		.ack_irq_o(ack_irq), .fwd_byte_o(fwd_byte), .fwd_valid_o(fwd_valid),
		.fwd_take_i(fwd_take), .rev_byte_i(line), .rev_valid_i(rev_valid),
		.cmd_byte_o(cmd_byte), .cmd_pending_o(cmd_pending), .cmd_sent_i(cmd_sent),
		.dma_request_line_o(dma_req), .dma_grant_line_i(dma_grant),
		.dma_count_done_i(dma_done));

	printer_model u_printer_model (
		.clk_i(clk), .resetn_i(resetn), .stall_i(stall), .pins_i(pins),
		.drive_i(drive), .unit_data_i(data_o), .unit_oe_i(data_oe),
		.fwd_byte_i(fwd_byte), .fwd_valid_i(fwd_valid), .cmd_pending_i(cmd_pending),
		.line_o(line), .port_in_o(port_in), .fwd_take_o(fwd_take),
		.cmd_sent_o(cmd_sent));

	// free-running 50 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// one apb transfer; an idle cycle after it avoids double drive of psel
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		int   n;
		logic ok;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		ok   = (pready === 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		// a slave that never answered counts as a mismatch
		if (!ok)
		begin
			fails++;
			end_sim();
		end
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdat, exp);
	endtask : rdc

	// bounded wait until the printer has taken k bytes
	task automatic wait_got(input int k);
		int c;
		c = 0;
		while (u_printer_model.got.size() < k && c < 300)
		begin
			@(posedge clk);
			c++;
		end
		if (u_printer_model.got.size() < k)
		begin
			fails++;
			end_sim();
		end
	endtask : wait_got

	task automatic watch_irq();
		hit = 1'b0;
		repeat (4)
		begin
			@(posedge clk);
			if (ack_irq === 1'b1)
				hit = 1'b1;
		end
	endtask : watch_irq

	task automatic t_reset();
		chk(port_out, 32'hb);
		chk(data_oe, 32'h1);
		rdc(IDX_CONTROL, 32'h0);
		rdc(IDX_FSTATUS, 32'h40);
		rdc(IDX_STATUS, 32'h3b);
	endtask : t_reset

	task automatic t_map();
		logic [9:0] bad [3] = '{10'h000, 10'h36f, 10'h380};
		foreach (bad[i])
		begin
			apb(1'b0, bad[i], 32'h0);
			chk(rerr, 32'h1);
		end
		rdc(10'h376, 32'h0);
		chk(rerr, 32'h0);
	endtask : t_map

	// forward drive, reverse bus turn-around and reverse queue with underrun
	task automatic t_line();
		wr(IDX_LINE, 32'ha5);
		cyc(2);
		chk(data_o, 32'ha5);
		rdc(IDX_LINE, 32'ha5);
		drive <= 8'h3c;
		wr(IDX_CONTROL, 32'h04);
		cyc(2);
		chk(data_oe, 32'h0);
		rdc(IDX_LINE, 32'h3c);
		drive     <= 8'h11;
		rev_valid <= 1'b1;
		@(posedge clk);
		drive <= 8'h22;
		@(posedge clk);
		rev_valid <= 1'b0;
		drive     <= 8'hdd;
		@(posedge clk);
		rdc(IDX_FSTATUS, 32'h62);
		apb(1'b0, IDX_QUEUE, 32'h0);
		chk(rdat[7:0], 32'h11);
		rdc(IDX_FSTATUS, 32'h61);
		apb(1'b0, IDX_QUEUE, 32'h0);
		chk(rdat[7:0], 32'h22);
		apb(1'b0, IDX_QUEUE, 32'h0);
		rdc(IDX_FSTATUS, 32'hc0);
		wr(IDX_FCONTROL, 32'h02);
		rdc(IDX_FSTATUS, 32'h40);
		wr(IDX_CONTROL, 32'h00);
	endtask : t_line

	task automatic t_status();
		pins <= 5'b10100;
		cyc(2);
		rdc(IDX_STATUS, 32'h24);
	endtask : t_status

	// each output bit alone flips exactly its own pin from the idle levels
	task automatic t_ctrl();
		for (int i = 4; i < 8; i++)
		begin
			wr(IDX_CONTROL, 32'h1 << i);
			cyc(2);
			chk(port_out, 32'hb ^ (32'h1 << (7 - i)));
			rdc(IDX_CONTROL, 32'h1 << i);
		end
		wr(IDX_CONTROL, 32'h00);
	endtask : t_ctrl

	task automatic t_ack();
		wr(IDX_CONTROL, 32'h08);
		pins.ack_n <= 1'b1;
		watch_irq();
		chk(hit, 32'h1);
		rdc(IDX_IRQ_CAUS, 32'h80);
		wr(IDX_CONTROL, 32'h00);
		pins.ack_n <= 1'b0;
		cyc(2);
		pins.ack_n <= 1'b1;
		watch_irq();
		chk(hit, 32'h0);
	endtask : t_ack

	// fill while the printer stalls, overrun, then drain in order
	task automatic t_fifo();
		stall <= 1'b1;
		for (int i = 1; i <= 16; i++)
			wr(IDX_QUEUE, i);
		rdc(IDX_FSTATUS, 32'h30);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rdat[6:5], 32'h2);
		wr(IDX_QUEUE, 32'h99);
		rdc(IDX_FSTATUS, 32'hb0);
		stall <= 1'b0;
		wait_got(16);
		foreach (u_printer_model.got[i])
			chk(u_printer_model.got[i], i + 1);
		rdc(IDX_FSTATUS, 32'hc0);
		wr(IDX_FCONTROL, 32'h02);
		rdc(IDX_FSTATUS, 32'h40);
		u_printer_model.got.delete();
	endtask : t_fifo

	task automatic t_wide();
		stall <= 1'b1;
		wr(IDX_FCONTROL, 32'h08);
		wr(IDX_QUEUE, 32'h44332211);
		rdc(IDX_FSTATUS, 32'h64);
		stall <= 1'b0;
		wait_got(4);
		chk({u_printer_model.got[3], u_printer_model.got[2],
			u_printer_model.got[1], u_printer_model.got[0]}, 32'h44332211);
		wr(IDX_FCONTROL, 32'h00);
	endtask : t_wide

	task automatic t_dma();
		wr(IDX_FCONTROL, 32'h01);
		cyc(1);
		chk(dma_req, 32'h1);
		dma_grant <= 1'b1;
		cyc(2);
		dma_grant <= 1'b0;
		chk(dma_req, 32'h0);
		wr(IDX_FCONTROL, 32'h01);
		cyc(1);
		chk(dma_req, 32'h0);
		dma_done <= 1'b1;
		@(posedge clk);
		dma_done <= 1'b0;
		wr(IDX_FCONTROL, 32'h01);
		cyc(1);
		chk(dma_req, 32'h1);
		dma_grant <= 1'b1;
		cyc(2);
		dma_grant <= 1'b0;
		wr(IDX_FCONTROL, 32'h00);
		wr(IDX_FCONTROL, 32'h01);
		cyc(1);
		chk(dma_req, 32'h1);
	endtask : t_dma

	task automatic t_cmd();
		stall <= 1'b1;
		wr(IDX_CMD, 32'h5e);
		chk(cmd_byte, 32'h5e);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rdat[7], 32'h1);
		rdc(IDX_CMD, 32'h5e);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rdat[7], 32'h0);
		wr(IDX_CMD, 32'h66);
		stall <= 1'b0;
		cyc(4);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rdat[7], 32'h0);
		stall <= 1'b1;
		wr(IDX_CMD, 32'h77);
		wr(IDX_CONTROL, 32'hf0);
		wr(IDX_FCONTROL, 32'h04);
		cyc(4);
		chk(port_out, 32'hb);
		rdc(IDX_CONTROL, 32'h0);
		chk(cmd_pending, 32'h0);
		stall <= 1'b0;
	endtask : t_cmd

	// reset for three cycles, then every scenario in turn
	initial
	begin
		fails      = 0;
		n_compared = 0;
		resetn     = 1'b0;
		{psel, penable, pwrite, rev_valid, stall, dma_grant, dma_done} = '0;
		paddr  = '0;
		pwdata = '0;
		drive  = 8'h00;
		pins   = 5'b01011;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_map();
		t_line();
		t_status();
		t_ctrl();
		t_ack();
		t_fifo();
		t_wide();
		t_dma();
		t_cmd();
		end_sim();
	end
endmodule : tb_top
